// File: psbp_pkg.sv
// constants and carrier types for the parallel slave byte port
// assumes a single 125 MHz clock domain and an 8-bit register address
package psbp_pkg;

    // register addresses, kept as the printed offsets
    localparam logic [7:0] ADDR_BYTE_PORT_LATCH    = 8'h08;
    localparam logic [7:0] ADDR_STROBE_PIN_PORT    = 8'h09;
    localparam logic [7:0] ADDR_PERIPH_IRQ_FLAGS   = 8'h0C;
    localparam logic [7:0] ADDR_BYTE_PORT_LATCH_DIRECTION    = 8'h88;
    localparam logic [7:0] ADDR_SLAVE_STATUS_DIR   = 8'h89;
    localparam logic [7:0] ADDR_PERIPH_IRQ_ENABLES = 8'h8C;
    localparam logic [7:0] ADDR_ANALOG_PIN_SETUP   = 8'h9F;

    // slave_status_direction field positions
    localparam int BIT_INPUT_FULL     = 7;
    localparam int BIT_OUTPUT_FULL    = 6;
    localparam int BIT_INPUT_OVERFLOW = 5;
    localparam int BIT_SLAVE_SELECT   = 4;
    localparam int BIT_STROBE_DIR_HI  = 2;

    // flag and enable position in the interrupt flag and enable registers
    localparam int BIT_PORT_IRQ = 7;

    // implemented bits of the analog pin setup register
    localparam logic [7:0] ANALOG_SETUP_MASK = 8'h8F;

    // reset values
    localparam logic [7:0] RST_PERIPH_IRQ_FLAGS   = 8'h00;
    localparam logic [7:0] RST_PERIPH_IRQ_ENABLES = 8'h00;
    localparam logic [7:0] RST_ANALOG_PIN_SETUP   = 8'h00;
    localparam logic [7:0] RST_BYTE_PORT_LATCH_DIRECTION    = 8'hFF;
    localparam logic [2:0] RST_STROBE_DIRECTION   = 3'h7;
    localparam logic [7:0] RST_BYTE               = 8'h00;

    // internal phase clock: four clock cycles per instruction cycle
    localparam logic [1:0] PHASE_TWO  = 2'h1;
    localparam logic [1:0] PHASE_FOUR = 2'h3;

    // host strobe pins as seen on the strobe pin port
    typedef struct packed {
        logic chip_select_n;
        logic store_strobe_n;
        logic read_strobe_n;
    } psbp_strobe_t;

    // firmware register request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } psbp_reg_req_t;

    // completion tracking after a strobe release
    typedef enum logic [1:0] {
        CMP_IDLE,
        CMP_WAIT_TWO,
        CMP_WAIT_FOUR
    } psbp_cmp_state_t;

endpackage : psbp_pkg

// File: psbp_slave_port.sv
// parallel slave byte port: host-facing byte latch, status flags and register file
// assumes strobe and data pins arrive asynchronously; registers via a plain port
//
// Notes on behaviour
// R1: slave_port_select turns data pins into a host read/write byte port.
// R2: two latches at one address: firmware writes output, reads input latch.
// R3: byte_port_latch_direction is ignored in slave mode; host strobes steer data pins.
// R4: host write ends on strobe release; input_full_flag set at phase_four after phase_two.
// R5: port_irq_flag is set together with input_full_flag on host write.
// R6: in slave mode only a firmware read of the input latch clears input_full_flag.
// R7: host write while input_full_flag still set raises input_overflow_flag.
// R8: input_overflow_flag stays until firmware clears it, even outside slave mode.
// R9: host read clears output_full_flag as soon as both strobes are seen low.
// R10: host read release sets port_irq_flag at phase_four after next phase_two.
// R11: output_full_flag stays low after host read until firmware writes latch.
// R12: input_full_flag and output_full_flag held zero while slave mode is off.
// R13: firmware clears port_irq_flag; interrupt request only while port_irq_enable set.
// R14: firmware sets the three strobe direction bits to inputs first.
// R15: firmware sets analog_pin_config so strobe pins are digital first.
// R16: strobe direction bits 2..0: one is input, zero is output, reset ones.
// R17: low read strobe is a read only while chip select is also low.
// R18: bit 3 of strobe_pin_port_direction is unimplemented and reads zero.
// R19: host strobes and data pass two flip-flops before any flag logic.
// R20: slave mode selects TTL input thresholds on data and strobe pins.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
`default_nettype none

module psbp_slave_port (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic [7:0] data_port_in,
    output logic      [7:0] data_port_out,
    output logic      [7:0] data_port_oe,
    input  wire logic [2:0] strobe_pin_in,
    output logic      [2:0] strobe_pin_out,
    output logic      [2:0] strobe_pin_oe,
    output logic            ttl_threshold_sel,
    output logic            port_irq
);

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [7:0]           data_meta_reg;
    logic [7:0]           data_sync_reg;
    psbp_pkg::psbp_strobe_t strobe_meta_reg;
    psbp_pkg::psbp_strobe_t strobe_sync_reg;
    psbp_pkg::psbp_reg_req_t req;

    // two stages on every pin; the first stage feeds only the second
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            data_meta_reg   <= 8'h00;
            data_sync_reg   <= 8'h00;
            strobe_meta_reg <= '1;
            strobe_sync_reg <= '1;
        end else begin
            data_meta_reg   <= data_port_in;                  // R19
            data_sync_reg   <= data_meta_reg;
            strobe_meta_reg <= {strobe_pin_in[2], strobe_pin_in[1], strobe_pin_in[0]};
            strobe_sync_reg <= strobe_meta_reg;               // R19
        end
    end

    assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    logic       slave_port_select_reg;
    logic [2:0] strobe_pin_port_direction_reg;
    logic [7:0] byte_port_latch_direction_reg;
    logic [7:0] irq_enables_reg;
    logic [7:0] analog_setup_reg;
    logic [7:0] out_latch_reg;
    logic [2:0] strobe_out_latch_reg;

    // plain firmware-written configuration
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            slave_port_select_reg <= 1'b0;
            strobe_pin_port_direction_reg   <= psbp_pkg::RST_STROBE_DIRECTION;   // R16
            byte_port_latch_direction_reg   <= psbp_pkg::RST_BYTE_PORT_LATCH_DIRECTION;
            irq_enables_reg       <= psbp_pkg::RST_PERIPH_IRQ_ENABLES;
            analog_setup_reg      <= psbp_pkg::RST_ANALOG_PIN_SETUP;
            out_latch_reg         <= psbp_pkg::RST_BYTE;
            strobe_out_latch_reg  <= 3'h0;
        end else if (req.wr) begin
            case (req.addr)
                psbp_pkg::ADDR_SLAVE_STATUS_DIR: begin
                    slave_port_select_reg <= req.wdata[psbp_pkg::BIT_SLAVE_SELECT];
                    strobe_pin_port_direction_reg   <= req.wdata[psbp_pkg::BIT_STROBE_DIR_HI:0];
                end
                psbp_pkg::ADDR_BYTE_PORT_LATCH_DIRECTION:    byte_port_latch_direction_reg <= req.wdata;
                psbp_pkg::ADDR_PERIPH_IRQ_ENABLES: irq_enables_reg     <= req.wdata;
                psbp_pkg::ADDR_ANALOG_PIN_SETUP: begin
                    analog_setup_reg <= req.wdata & psbp_pkg::ANALOG_SETUP_MASK;
                end
                psbp_pkg::ADDR_BYTE_PORT_LATCH:    out_latch_reg <= req.wdata;   // R2
                psbp_pkg::ADDR_STROBE_PIN_PORT:    strobe_out_latch_reg <= req.wdata[2:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // phase clock and host strobe decode
    // ----------------------------------------------------------------
    logic [1:0] phase_cnt_reg;
    logic       wr_act;
    logic       rd_act;
    logic       wr_act_prev_reg;
    logic       rd_act_prev_reg;
    logic       wr_release;
    logic       rd_release;
    logic       rd_start;

    // free-running four-phase counter stands in for the instruction phases
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            phase_cnt_reg <= 2'h0;
        end else begin
            phase_cnt_reg <= phase_cnt_reg + 2'h1;
        end
    end

    // chip select qualifies both strobes; level triggered
    assign wr_act = slave_port_select_reg & ~strobe_sync_reg.chip_select_n
                    & ~strobe_sync_reg.store_strobe_n;                      // R4
    assign rd_act = slave_port_select_reg & ~strobe_sync_reg.chip_select_n
                    & ~strobe_sync_reg.read_strobe_n;                       // R17

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_act_prev_reg <= 1'b0;
            rd_act_prev_reg <= 1'b0;
        end else begin
            wr_act_prev_reg <= wr_act;
            rd_act_prev_reg <= rd_act;
        end
    end

    assign wr_release = wr_act_prev_reg & ~wr_act;
    assign rd_release = rd_act_prev_reg & ~rd_act;
    assign rd_start   = rd_act & ~rd_act_prev_reg;

    // ----------------------------------------------------------------
    // completion timing: next phase_two, then its phase_four
    // ----------------------------------------------------------------
    psbp_pkg::psbp_cmp_state_t wr_cmp_reg;
    psbp_pkg::psbp_cmp_state_t rd_cmp_reg;
    logic                      wr_done;
    logic                      rd_done;

    // a mode drop abandons a pending completion, the full flags are held clear anyway
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_cmp_reg <= psbp_pkg::CMP_IDLE;
        end else if (!slave_port_select_reg) begin
            wr_cmp_reg <= psbp_pkg::CMP_IDLE;
        end else begin
            case (wr_cmp_reg)
                psbp_pkg::CMP_IDLE: if (wr_release) wr_cmp_reg <= psbp_pkg::CMP_WAIT_TWO; // R4
                psbp_pkg::CMP_WAIT_TWO: if (phase_cnt_reg == psbp_pkg::PHASE_TWO)
                    wr_cmp_reg <= psbp_pkg::CMP_WAIT_FOUR;
                psbp_pkg::CMP_WAIT_FOUR: if (phase_cnt_reg == psbp_pkg::PHASE_FOUR)
                    wr_cmp_reg <= psbp_pkg::CMP_IDLE;
                default: wr_cmp_reg <= psbp_pkg::CMP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_cmp_reg <= psbp_pkg::CMP_IDLE;
        end else if (!slave_port_select_reg) begin
            rd_cmp_reg <= psbp_pkg::CMP_IDLE;
        end else begin
            case (rd_cmp_reg)
                psbp_pkg::CMP_IDLE: if (rd_release) rd_cmp_reg <= psbp_pkg::CMP_WAIT_TWO; // R10
                psbp_pkg::CMP_WAIT_TWO: if (phase_cnt_reg == psbp_pkg::PHASE_TWO)
                    rd_cmp_reg <= psbp_pkg::CMP_WAIT_FOUR;
                psbp_pkg::CMP_WAIT_FOUR: if (phase_cnt_reg == psbp_pkg::PHASE_FOUR)
                    rd_cmp_reg <= psbp_pkg::CMP_IDLE;
                default: rd_cmp_reg <= psbp_pkg::CMP_IDLE;
            endcase
        end
    end

    assign wr_done = (wr_cmp_reg == psbp_pkg::CMP_WAIT_FOUR)
                     && (phase_cnt_reg == psbp_pkg::PHASE_FOUR);
    assign rd_done = (rd_cmp_reg == psbp_pkg::CMP_WAIT_FOUR)
                     && (phase_cnt_reg == psbp_pkg::PHASE_FOUR);

    // ----------------------------------------------------------------
    // input latch and status flags
    // ----------------------------------------------------------------
    logic [7:0] in_latch_reg;
    logic       input_full_flag_reg;
    logic       output_full_flag_reg;
    logic       input_overflow_flag_reg;
    logic       port_irq_flag_reg;
    logic       fw_read_latch;
    logic       fw_write_latch;
    logic       fw_write_status;

    assign fw_read_latch   = req.rd && (req.addr == psbp_pkg::ADDR_BYTE_PORT_LATCH);
    assign fw_write_latch  = req.wr && (req.addr == psbp_pkg::ADDR_BYTE_PORT_LATCH);
    assign fw_write_status = req.wr && (req.addr == psbp_pkg::ADDR_SLAVE_STATUS_DIR);

    // the latch tracks the bus while the host holds its write, so the last
    // sampled byte is what remains once the strobe lifts
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            in_latch_reg <= psbp_pkg::RST_BYTE;
        end else if (wr_act) begin
            in_latch_reg <= data_sync_reg;                                  // R2
        end
    end

    // hardware set wins over a same-cycle firmware read
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            input_full_flag_reg <= 1'b0;
        end else if (!slave_port_select_reg) begin
            input_full_flag_reg <= 1'b0;                                    // R12
        end else if (wr_done) begin
            input_full_flag_reg <= 1'b1;                                    // R4
        end else if (fw_read_latch) begin
            input_full_flag_reg <= 1'b0;                                    // R6
        end
    end

    // a firmware write refilling the latch wins over a host read start
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            output_full_flag_reg <= 1'b0;
        end else if (!slave_port_select_reg) begin
            output_full_flag_reg <= 1'b0;                                   // R12
        end else if (fw_write_latch) begin
            output_full_flag_reg <= 1'b1;                                   // R11
        end else if (rd_start) begin
            output_full_flag_reg <= 1'b0;                                   // R9
        end
    end

    // sticky across mode changes; only a firmware write of zero clears it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            input_overflow_flag_reg <= 1'b0;
        end else if (wr_done && input_full_flag_reg) begin
            input_overflow_flag_reg <= 1'b1;                                // R7
        end else if (fw_write_status) begin
            input_overflow_flag_reg <= req.wdata[psbp_pkg::BIT_INPUT_OVERFLOW]; // R8
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            port_irq_flag_reg <= psbp_pkg::RST_PERIPH_IRQ_FLAGS[psbp_pkg::BIT_PORT_IRQ];
        end else if (wr_done || rd_done) begin
            port_irq_flag_reg <= 1'b1;                                      // R5 R10
        end else if (req.wr && (req.addr == psbp_pkg::ADDR_PERIPH_IRQ_FLAGS)) begin
            port_irq_flag_reg <= req.wdata[psbp_pkg::BIT_PORT_IRQ];         // R13
        end
    end

    // ----------------------------------------------------------------
    // pin drivers and interrupt request
    // ----------------------------------------------------------------
    // data pins: host read strobes set direction in slave mode, else byte_port_latch_direction
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            data_port_out     <= psbp_pkg::RST_BYTE;
            data_port_oe      <= 8'h00;
            strobe_pin_out    <= 3'h0;
            strobe_pin_oe     <= 3'h0;
            ttl_threshold_sel <= 1'b0;
            port_irq          <= 1'b0;
        end else begin
            data_port_out     <= out_latch_reg;
            data_port_oe      <= slave_port_select_reg ? {8{rd_act}}       // R1 R3
                                                       : ~byte_port_latch_direction_reg;
            strobe_pin_out    <= strobe_out_latch_reg;
            strobe_pin_oe     <= ~strobe_pin_port_direction_reg;                      // R16
            ttl_threshold_sel <= slave_port_select_reg;                     // R20
            port_irq          <= port_irq_flag_reg
                                 & irq_enables_reg[psbp_pkg::BIT_PORT_IRQ]; // R13
        end
    end

    // ----------------------------------------------------------------
    // register read port
    // ----------------------------------------------------------------
    logic [7:0] rdata_next;

    always_comb begin
        rdata_next = 8'h00;
        case (req.addr)
            psbp_pkg::ADDR_BYTE_PORT_LATCH: begin
                rdata_next = slave_port_select_reg ? in_latch_reg : data_sync_reg; // R2
            end
            psbp_pkg::ADDR_STROBE_PIN_PORT: begin
                rdata_next = {5'h00, strobe_sync_reg.chip_select_n,
                              strobe_sync_reg.store_strobe_n,
                              strobe_sync_reg.read_strobe_n};
            end
            psbp_pkg::ADDR_PERIPH_IRQ_FLAGS:   rdata_next = {port_irq_flag_reg, 7'h00};
            psbp_pkg::ADDR_BYTE_PORT_LATCH_DIRECTION: rdata_next = byte_port_latch_direction_reg;
            psbp_pkg::ADDR_SLAVE_STATUS_DIR: begin
                rdata_next = {input_full_flag_reg, output_full_flag_reg,
                              input_overflow_flag_reg, slave_port_select_reg,
                              1'b0, strobe_pin_port_direction_reg};                   // R18
            end
            psbp_pkg::ADDR_PERIPH_IRQ_ENABLES: rdata_next = irq_enables_reg;
            psbp_pkg::ADDR_ANALOG_PIN_SETUP:   rdata_next = analog_setup_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= req.rd ? rdata_next : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    localparam int CMP_LO = 3;
    localparam int CMP_HI = 8;

    sequence s_wr_release;
        wr_act ##1 (!wr_act && slave_port_select_reg);
    endsequence

    sequence s_rd_release;
        rd_act ##1 (!rd_act && slave_port_select_reg);
    endsequence

    a_ibf_on_four: assert property (@(posedge clock) disable iff (rst)   // R4
        $rose(input_full_flag_reg) |-> $past(phase_cnt_reg) == psbp_pkg::PHASE_FOUR)
        else $error("input full flag rose off phase four");

    a_wr_completes: assert property (@(posedge clock) disable iff (rst)  // R4
        s_wr_release |-> ##[CMP_LO:CMP_HI]
            (input_full_flag_reg || !slave_port_select_reg))
        else $error("host write did not complete in time");

    a_irq_with_ibf: assert property (@(posedge clock) disable iff (rst)  // R5
        $rose(input_full_flag_reg) |-> port_irq_flag_reg)
        else $error("irq flag missing with input full");

    a_rd_completes: assert property (@(posedge clock) disable iff (rst)  // R10
        (s_rd_release ##0 !port_irq_flag_reg) |-> ##[CMP_LO:CMP_HI]
            (port_irq_flag_reg || !slave_port_select_reg))
        else $error("host read did not raise irq flag");

    a_obf_cleared: assert property (@(posedge clock) disable iff (rst)   // R9
        (rd_start && !fw_write_latch) |=> !output_full_flag_reg)
        else $error("output full not cleared by host read");

    a_flags_held: assert property (@(posedge clock) disable iff (rst)    // R12
        !slave_port_select_reg |=> !input_full_flag_reg && !output_full_flag_reg)
        else $error("flags not held clear outside slave mode");

    a_ovf_sticky: assert property (@(posedge clock) disable iff (rst)    // R8
        (input_overflow_flag_reg && !fw_write_status) |=> input_overflow_flag_reg)
        else $error("overflow flag dropped without firmware");

    a_ovf_on_full: assert property (@(posedge clock) disable iff (rst)   // R7
        (wr_done && input_full_flag_reg) |=> input_overflow_flag_reg)
        else $error("overflow not flagged on second write");

    a_irq_gated: assert property (@(posedge clock) disable iff (rst)     // R13
        !irq_enables_reg[psbp_pkg::BIT_PORT_IRQ] |=> !port_irq)
        else $error("interrupt raised while disabled");

    a_bit3_zero: assert property (@(posedge clock) disable iff (rst)     // R18
        (req.rd && req.addr == psbp_pkg::ADDR_SLAVE_STATUS_DIR) |=> !reg_rdata[3])
        else $error("unimplemented direction bit read as one");

    a_oe_host_read: assert property (@(posedge clock) disable iff (rst)  // R3
        (slave_port_select_reg && !rd_act) |=> data_port_oe == 8'h00)
        else $error("data pins driven without host read");

endmodule : psbp_slave_port

`default_nettype wire

// File: psbp_host_model.sv
// host model: an external byte-wide bus master on the slave port pins
// assumes it is paced by the design clock; strobes idle high between transfers
`timescale 1ns/1ns
`default_nettype none

module psbp_host_model (
    input  wire logic              clock,
    input  wire logic [7:0]        dev_data_out,
    input  wire logic [7:0]        dev_data_oe,
    output logic      [7:0]        data_wire,
    output psbp_pkg::psbp_strobe_t strobes = 3'h7
);
    logic [7:0] host_data = 8'h00;
    logic       host_oe   = 1'b0;
    logic [7:0] last_wire = 8'h00;

    // -------------------------------------------------------------
    // data wire resolution
    // -------------------------------------------------------------
    // undriven bits toggle so a stale value can never pass for data
    always_comb begin
        data_wire = (dev_data_oe & dev_data_out) | (~dev_data_oe & ~last_wire);
        if (host_oe)
            data_wire = host_data;
    end
    always @(posedge clock) last_wire <= data_wire;

    // write: chip select and store strobe low, data held past release
    task automatic host_write(input logic [7:0] value);
        host_data <= value;
        host_oe <= 1'b1;
        strobes <= 3'h1;
        repeat (6) @(posedge clock);
        strobes <= 3'h7;
        repeat (2) @(posedge clock);
        host_oe <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : host_write

    // read: chip select and read strobe low, sample before release
    task automatic host_read(output logic [7:0] value);
        strobes <= 3'h2;
        repeat (6) @(posedge clock);
        value = data_wire;
        strobes <= 3'h7;
        repeat (2) @(posedge clock);
    endtask : host_read
endmodule : psbp_host_model

`default_nettype wire

// File: testbench.sv
// self-checking bench for the parallel slave byte port
// assumes the host model on the pins and the plain register port
`timescale 1ns/1ns
`default_nettype none

module testbench;
    logic                   clock = 1'b0;
    logic                   rst = 1'b1;
    logic [7:0]             reg_addr = 8'h00;
    logic [7:0]             reg_wdata = 8'h00;
    logic                   reg_wr = 1'b0;
    logic                   reg_rd = 1'b0;
    logic [7:0]             reg_rdata, d_out, d_oe, d_wire, rd_val;
    logic [2:0]             s_out, s_oe;
    logic                   ttl_sel, port_irq;
    psbp_pkg::psbp_strobe_t strobes;
    int                     err_total = 0;
    int                     tests_run = 0;

    always #4 clock = ~clock;

    psbp_slave_port i_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .data_port_in(d_wire), .data_port_out(d_out), .data_port_oe(d_oe),
        .strobe_pin_in(strobes), .strobe_pin_out(s_out), .strobe_pin_oe(s_oe),
        .ttl_threshold_sel(ttl_sel), .port_irq(port_irq));
    psbp_host_model i_host (.clock(clock), .dev_data_out(d_out), .dev_data_oe(d_oe),
        .data_wire(d_wire), .strobes(strobes));

    // -------------------------------------------------------------
    // bus and compare tasks: all enter and leave just after a rising edge, except check, which chk_reg calls just after a falling edge
    // -------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask : reg_write
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        check($sformatf("register %h", a), exp, reg_rdata);
        @(posedge clock);
    endtask : chk_reg
    // completion can take several phase cycles, so poll with a bound
    task automatic wait_irq;
        int n;
        n = 0;
        while (port_irq !== 1'b1 && n < 40) begin
            @(posedge clock);
            n++;
        end
        if (port_irq !== 1'b1) begin
            err_total++;
            $display("mismatch port_irq expected 1 seen %b", port_irq);
            results();
        end
    endtask : wait_irq
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    task automatic t_reset_setup;
        chk_reg(8'h89, 8'h07);
        chk_reg(8'h0C, 8'h00);
        chk_reg(8'h40, 8'h00);
        reg_write(8'h9F, 8'h06);
        chk_reg(8'h9F, 8'h06);
        reg_write(8'h89, 8'hFF);
        chk_reg(8'h89, 8'h37);
        reg_write(8'h89, 8'h17);
        chk_reg(8'h89, 8'h17);
        check("ttl select", 8'h01, {7'h00, ttl_sel});
        check("strobe oe", 8'h00, {5'h00, s_oe});
        reg_write(8'h88, 8'h00);
        reg_write(8'h8C, 8'h80);
        check("data oe", 8'h00, d_oe);
    endtask : t_reset_setup
    // second write before the first byte is taken overflows
    task automatic t_write_overflow;
        i_host.host_write(8'hA5);
        wait_irq();
        chk_reg(8'h89, 8'h97);
        chk_reg(8'h0C, 8'h80);
        reg_write(8'h0C, 8'h00);
        i_host.host_write(8'h5A);
        wait_irq();
        chk_reg(8'h89, 8'hB7);
        chk_reg(8'h08, 8'h5A);
        chk_reg(8'h89, 8'h37);
        reg_write(8'h0C, 8'h00);
    endtask : t_write_overflow
    task automatic t_host_read;
        reg_write(8'h08, 8'h3C);
        chk_reg(8'h89, 8'h77);
        i_host.host_read(rd_val);
        check("host read data", 8'h3C, rd_val);
        wait_irq();
        chk_reg(8'h89, 8'h37);
        reg_write(8'h8C, 8'h00);
        repeat (2) @(posedge clock);
        check("masked irq", 8'h00, {7'h00, port_irq});
        chk_reg(8'h0C, 8'h80);
        reg_write(8'h0C, 8'h00);
    endtask : t_host_read
    task automatic t_mode_off;
        reg_write(8'h08, 8'h11);
        i_host.host_write(8'hC3);
        repeat (8) @(posedge clock);
        chk_reg(8'h89, 8'hF7);
        reg_write(8'h89, 8'h27);
        chk_reg(8'h89, 8'h27);
        check("data oe", 8'hFF, d_oe);
        reg_write(8'h89, 8'h07);
        chk_reg(8'h89, 8'h07);
    endtask : t_mode_off

    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset_setup();
        t_write_overflow();
        t_host_read();
        t_mode_off();
        results();
    end
endmodule : testbench

`default_nettype wire
